//--- pkg/isa_map.svh
// Constants for the two-wire slave addressing engine
`ifndef ISA_MAP_SVH
`define ISA_MAP_SVH

// ==========================================================
// Address matching
`define ISA_TEN_BIT_HDR 5'h1e
`define ISA_GEN_CALL_ADDR 8'h00
`define ISA_RW_BIT 0

// ==========================================================
// Bit counter positions (counted in rising SCL edges)
`define ISA_CNT_BYTE 4'h8
`define ISA_CNT_ACK 4'h9
`define ISA_CNT_ZERO 4'h0

// ==========================================================
// Reset values
`define ISA_OWN_ADDR_RST 8'h00
`define ISA_BYTE_RST 8'h00

// ==========================================================
// Crossing
`define ISA_NUM_EVT 4
`define ISA_EVT_RISE 0
`define ISA_EVT_FALL 1
`define ISA_EVT_START 2
`define ISA_EVT_STOP 3

`endif

//--- pkg/isa_pkg.sv
// Types shared by the two-wire slave addressing engine
package isa_pkg;

   // ==========================================================
   // Engine states, Gray coded along the usual path
   typedef enum logic [2:0]
   {
      ISA_IDLE  = 3'h0,
      ISA_ADDR  = 3'h1,
      ISA_ADDR2 = 3'h3,
      ISA_RX    = 3'h2,
      ISA_TX    = 3'h6,
      ISA_WAIT  = 3'h7
   } isa_state_t;

   // ==========================================================
   // Byte and counter types
   typedef logic [7:0] isa_byte_t;
   typedef logic [3:0] isa_cnt_t;

endpackage

//--- design/isa_evt_sync.sv
// Toggle to pulse synchroniser for link events entering the core clock
`timescale 1ns/1ns
`include "isa_map.svh"
module isa_evt_sync
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Toggles from the link domain
   input wire logic [`ISA_NUM_EVT-1:0] tgl_i,
   // One-cycle pulses in the core domain
   output logic [`ISA_NUM_EVT-1:0] pulse_o
);

   genvar gi;

   // ==========================================================
   // Per event: two flops, then one for edge detection
   generate
      for (gi = 0; gi < `ISA_NUM_EVT; gi++)
      begin : g_evt
         logic meta_q;
         logic sync_q;
         logic prev_q;
         logic meta_d;
         logic sync_d;
         logic prev_d;

         // Next values
         always_comb
         begin
            meta_d = tgl_i[gi];
            sync_d = meta_q;
            prev_d = sync_q;
            if (!resetn_i)
            begin
               meta_d = 1'b0;
               sync_d = 1'b0;
               prev_d = 1'b0;
            end
         end

         // Registers
         always_ff @(posedge clk_i)
         begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
         end

         assign pulse_o[gi] = sync_q ^ prev_q; // Edge of the toggle
      end
   endgenerate

endmodule

//--- design/isa_link_front.sv
// Link-clock front end: pin sampling, SCL edges, start and stop detection
`timescale 1ns/1ns
`include "isa_map.svh"
module isa_link_front
(
   // Link clock and core reset level
   input wire logic link_clk_i,
   input wire logic resetn_i,
   // Pin levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Event toggles and sampled data bit
   output logic [`ISA_NUM_EVT-1:0] tgl_o,
   output logic sda_bit_o
);

   logic rst_meta_q, rst_q;
   logic scl_meta_q, scl_q, scl_p_q;
   logic sda_meta_q, sda_q, sda_p_q;
   logic [`ISA_NUM_EVT-1:0] tgl_q, tgl_d, hit;
   logic sda_bit_q, sda_bit_d;

   // ==========================================================
   // Reset and pin synchronisers
   always_ff @(posedge link_clk_i)
   begin
      rst_meta_q <= resetn_i;
      rst_q <= rst_meta_q;
      scl_meta_q <= scl_i;
      scl_q <= scl_meta_q;
      scl_p_q <= scl_q;
      sda_meta_q <= sda_i;
      sda_q <= sda_meta_q;
      sda_p_q <= sda_q;
   end

   // Edge and condition detection
   always_comb
   begin
      hit[`ISA_EVT_RISE] = scl_q & ~scl_p_q;
      hit[`ISA_EVT_FALL] = ~scl_q & scl_p_q;
      hit[`ISA_EVT_START] = scl_q & scl_p_q & sda_p_q & ~sda_q;
      hit[`ISA_EVT_STOP] = scl_q & scl_p_q & ~sda_p_q & sda_q;
      tgl_d = tgl_q ^ hit;
      sda_bit_d = hit[`ISA_EVT_RISE] ? sda_q : sda_bit_q; // Held until next rise
      if (!rst_q)
      begin
         tgl_d = '0;
         sda_bit_d = 1'b1;
      end
   end

   // Event registers
   always_ff @(posedge link_clk_i)
   begin
      tgl_q <= tgl_d;
      sda_bit_q <= sda_bit_d;
   end

   assign tgl_o = tgl_q;
   assign sda_bit_o = sda_bit_q;

endmodule

//--- design/isa_slave.sv
// Two-wire slave addressing engine: matching, receive, transmit, flags
`timescale 1ns/1ns
`include "isa_map.svh"
module isa_slave
   import isa_pkg::*;
(
   // Clocks and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic LINK_CLK_I,
   // Bus pins, open drain
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_O,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   // Configuration
   input wire logic ENABLE_I,
   input wire logic TEN_BIT_I,
   input wire logic MASTER_MODE_I,
   input wire logic GEN_CALL_EN_I,
   input wire logic SLEEP_I,
   input wire logic EVENT_IE_I,
   // Firmware strobes
   input wire logic ADDR_WR_I,
   input wire isa_pkg::isa_byte_t ADDR_DATA_I,
   input wire logic BUF_WR_I,
   input wire isa_pkg::isa_byte_t BUF_DATA_I,
   input wire logic BUF_RD_I,
   input wire logic FLAG_CLR_I,
   input wire logic OVF_CLR_I,
   input wire logic CLK_RELEASE_SET_I,
   // Status
   output isa_pkg::isa_byte_t BUF_DATA_O,
   output isa_pkg::isa_byte_t OWN_ADDR_O,
   output logic SERIAL_EVENT_FLAG_O,
   output logic BUFFER_FULL_O,
   output logic RECEIVE_OVERFLOW_O,
   output logic UPDATE_ADDRESS_O,
   output logic DIR_READ_O,
   output logic DATA_NOT_ADDR_O,
   output logic START_SEEN_O,
   output logic STOP_SEEN_O,
   output logic BUS_FREE_O,
   output logic CLOCK_RELEASE_O,
   output logic WAKE_O
);

   import isa_pkg::*;

   logic [`ISA_NUM_EVT-1:0] tgl, ev;
   logic sda_bit;
   logic ev_rise, ev_fall, ev_start, ev_stop;
   isa_state_t st_q, st_d, nxt_q, nxt_d;
   isa_cnt_t cnt_q, cnt_d;
   isa_byte_t sr_q, sr_d, buf_q, buf_d, own_q, own_d;
   logic flag_q, flag_d, bf_q, bf_d, ovf_q, ovf_d, ua_q, ua_d;
   logic ua_pend_q, ua_pend_d, dir_q, dir_d, dna_q, dna_d;
   logic ack_q, ack_d, armed_q, armed_d, rel_q, rel_d;
   logic ss_q, ss_d, ps_q, ps_d, wake_q, wake_d, gc_q, gc_d;
   logic room, m7, hi10, gc_hit;

   // ==========================================================
   // Link front end and crossing
   isa_link_front u_front
   (
      .link_clk_i(LINK_CLK_I),
      .resetn_i(RESETN_I),
      .scl_i(SCL_I),
      .sda_i(SDA_I),
      .tgl_o(tgl),
      .sda_bit_o(sda_bit)
   );

   isa_evt_sync u_sync
   (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .tgl_i(tgl),
      .pulse_o(ev)
   );

   assign ev_rise = ev[`ISA_EVT_RISE];
   assign ev_fall = ev[`ISA_EVT_FALL];
   assign ev_start = ev[`ISA_EVT_START];
   assign ev_stop = ev[`ISA_EVT_STOP];

   // Match terms on the received byte
   assign room = ~bf_q & ~ovf_q;
   assign m7 = (sr_q[7:1] == own_q[7:1]);
   assign hi10 = (sr_q[7:3] == `ISA_TEN_BIT_HDR);
   assign gc_hit = GEN_CALL_EN_I & (sr_q == `ISA_GEN_CALL_ADDR);

   // ==========================================================
   // Engine next state
   always_comb
   begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      sr_d = sr_q;
      buf_d = buf_q;
      own_d = own_q;
      flag_d = flag_q & ~FLAG_CLR_I;
      bf_d = bf_q & ~BUF_RD_I;
      ovf_d = ovf_q & ~OVF_CLR_I;
      ua_d = ua_q & ~ADDR_WR_I;
      ua_pend_d = ua_pend_q;
      dir_d = dir_q;
      dna_d = dna_q;
      ack_d = ack_q;
      armed_d = armed_q;
      rel_d = rel_q | CLK_RELEASE_SET_I;
      ss_d = ss_q;
      ps_d = ps_q;
      gc_d = gc_q;
      // Firmware writes
      if (ADDR_WR_I)
      begin
         own_d = ADDR_DATA_I;
      end
      if (BUF_WR_I)
      begin
         buf_d = BUF_DATA_I;
         sr_d = BUF_DATA_I;
      end
      // Start and stop conditions
      if (ev_start)
      begin
         ss_d = 1'b1;
         ps_d = 1'b0;
         st_d = ISA_ADDR;
         cnt_d = `ISA_CNT_ZERO;
         ack_d = 1'b0;
         gc_d = 1'b0;
         flag_d = flag_d | MASTER_MODE_I;
      end
      else if (ev_stop)
      begin
         ss_d = 1'b0;
         ps_d = 1'b1;
         st_d = ISA_IDLE;
         armed_d = 1'b0;
         ack_d = 1'b0;
         flag_d = flag_d | MASTER_MODE_I;
      end
      // Rising SCL: shift in, or latch master acknowledge
      else if (ev_rise && st_q != ISA_IDLE)
      begin
         if (cnt_q < `ISA_CNT_BYTE)
         begin
            cnt_d = cnt_q + 4'h1;
            if (st_q != ISA_TX)
            begin
               sr_d = {sr_q[6:0], sda_bit};
            end
         end
         else if (cnt_q == `ISA_CNT_BYTE)
         begin
            cnt_d = `ISA_CNT_ACK;
            if (st_q == ISA_TX && sda_bit)
            begin
               dir_d = 1'b0;
               nxt_d = ISA_WAIT;
            end
         end
      end
      // Falling SCL
      else if (ev_fall && st_q != ISA_IDLE)
      begin
         if (st_q == ISA_TX && cnt_q != `ISA_CNT_ZERO && cnt_q < `ISA_CNT_BYTE)
         begin
            sr_d = {sr_q[6:0], 1'b0};
         end
         if (cnt_q == `ISA_CNT_BYTE && !MASTER_MODE_I && st_q != ISA_WAIT)
         begin
            ack_d = 1'b0;
            nxt_d = ISA_WAIT;
            if (st_q == ISA_TX)
            begin
               nxt_d = ISA_TX;
               sr_d = 8'hff; // Let go of SDA for the master's acknowledge
            end
            else if (st_q == ISA_RX)
            begin
               dna_d = 1'b1;
               ack_d = room;
               nxt_d = ISA_RX;
               if (!bf_q)
               begin
                  buf_d = sr_q;
                  bf_d = 1'b1;
               end
               else
               begin
                  ovf_d = 1'b1;
               end
            end
            else
            begin
               dna_d = 1'b0;
               if (st_q == ISA_ADDR && gc_hit)
               begin
                  nxt_d = ISA_RX;
                  gc_d = 1'b1;
                  dir_d = 1'b0;
               end
               else if (st_q == ISA_ADDR2 && sr_q == own_q)
               begin
                  nxt_d = ISA_RX;
                  ua_pend_d = 1'b1;
                  armed_d = 1'b1;
               end
               else if (st_q == ISA_ADDR && m7 && (!TEN_BIT_I || hi10))
               begin
                  if (!sr_q[`ISA_RW_BIT])
                  begin
                     dir_d = 1'b0;
                     nxt_d = TEN_BIT_I ? ISA_ADDR2 : ISA_RX;
                     ua_pend_d = TEN_BIT_I;
                  end
                  else if (!TEN_BIT_I || armed_q)
                  begin
                     dir_d = 1'b1;
                     nxt_d = ISA_TX;
                  end
               end
               if (nxt_d != ISA_WAIT)
               begin
                  ack_d = room;
                  if (!bf_q)
                  begin
                     buf_d = sr_q;
                     bf_d = 1'b1;
                  end
                  else
                  begin
                     ovf_d = 1'b1;
                  end
                  if (!room)
                  begin
                     nxt_d = ISA_WAIT;
                     ua_pend_d = 1'b0;
                  end
               end
            end
         end
         else if (cnt_q == `ISA_CNT_ACK)
         begin
            cnt_d = `ISA_CNT_ZERO;
            ack_d = 1'b0;
            if (MASTER_MODE_I)
            begin
               flag_d = 1'b1;
            end
            else if (st_q != ISA_WAIT)
            begin
               // A refused address raises no event; a sent byte always does
               if (nxt_q != ISA_WAIT || st_q == ISA_TX)
               begin
                  flag_d = 1'b1;
               end
               st_d = nxt_q;
               ua_d = ua_pend_q;
               ua_pend_d = 1'b0;
               if (nxt_q == ISA_TX)
               begin
                  rel_d = 1'b0;
               end
            end
         end
      end
      // Disabled port or device reset aborts the transfer and clears status; only reset also clears the buffer and own address
      if (!ENABLE_I || !RESETN_I)
      begin
         st_d = ISA_IDLE;
         nxt_d = ISA_IDLE;
         cnt_d = `ISA_CNT_ZERO;
         sr_d = `ISA_BYTE_RST;
         flag_d = 1'b0;
         bf_d = 1'b0;
         ovf_d = 1'b0;
         ua_d = 1'b0;
         ua_pend_d = 1'b0;
         dir_d = 1'b0;
         dna_d = 1'b0;
         ack_d = 1'b0;
         armed_d = 1'b0;
         rel_d = 1'b1;
         ss_d = 1'b0;
         ps_d = 1'b0;
         gc_d = 1'b0;
      end
      if (!RESETN_I)
      begin
         buf_d = `ISA_BYTE_RST;
         own_d = `ISA_OWN_ADDR_RST;
      end
      wake_d = SLEEP_I & EVENT_IE_I & flag_d;
   end

   // Engine registers
   always_ff @(posedge CLK_I)
   begin
      st_q <= st_d;
      nxt_q <= nxt_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      buf_q <= buf_d;
      own_q <= own_d;
      flag_q <= flag_d;
      bf_q <= bf_d;
      ovf_q <= ovf_d;
      ua_q <= ua_d;
      ua_pend_q <= ua_pend_d;
      dir_q <= dir_d;
      dna_q <= dna_d;
      ack_q <= ack_d;
      armed_q <= armed_d;
      rel_q <= rel_d;
      ss_q <= ss_d;
      ps_q <= ps_d;
      wake_q <= wake_d;
      gc_q <= gc_d;
   end

   // ==========================================================
   // Pin drive: open drain, enable pulls low
   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;
   assign SCL_OE_O = ua_q | ~rel_q;
   assign SDA_OE_O = ack_q | (st_q == ISA_TX && !sr_q[7]);

   // Status outputs
   assign BUF_DATA_O = buf_q;
   assign OWN_ADDR_O = own_q;
   assign SERIAL_EVENT_FLAG_O = flag_q;
   assign BUFFER_FULL_O = bf_q;
   assign RECEIVE_OVERFLOW_O = ovf_q;
   assign UPDATE_ADDRESS_O = ua_q;
   assign DIR_READ_O = dir_q;
   assign DATA_NOT_ADDR_O = dna_q;
   assign START_SEEN_O = ss_q;
   assign STOP_SEEN_O = ps_q;
   assign BUS_FREE_O = ps_q | (~ss_q & ~ps_q);
   assign CLOCK_RELEASE_O = rel_q;
   assign WAKE_O = wake_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   chk_nack_when_full: assert property (ev_fall && cnt_q == `ISA_CNT_BYTE && st_q == ISA_RX && bf_q
      |=> !ack_q) else $error("ack given while buffer full");
   chk_full_keeps_buf: assert property (ev_fall && cnt_q == `ISA_CNT_BYTE && st_q == ISA_RX && bf_q
      && !BUF_WR_I |=> buf_q == $past(buf_q) && ovf_q) else $error("full buffer overwritten");
   chk_flag_sticky: assert property (flag_q && !FLAG_CLR_I && ENABLE_I |=> flag_q)
      else $error("event flag cleared by hardware");
   chk_read_clears: assert property (BUF_RD_I && !ev_fall && ENABLE_I |=> !bf_q)
      else $error("buffer read did not clear full");
   chk_ua_holds_scl: assert property (ua_q |-> SCL_OE_O)
      else $error("SCL released during address update");
   chk_ua_until_write: assert property (ua_q && !ADDR_WR_I && ENABLE_I |=> ua_q)
      else $error("address update flag dropped without a write");
   chk_nack_resets: assert property (st_q == ISA_TX && ev_rise && cnt_q == `ISA_CNT_BYTE && sda_bit
      && ENABLE_I && !ev_start |=> !dir_q && nxt_q == ISA_WAIT) else $error("NACK did not reset");
   chk_tx_on_fall: assert property (st_q == ISA_TX && ev_rise && !BUF_WR_I && ENABLE_I
      |=> $stable(SDA_OE_O)) else $error("SDA moved on rising SCL");
   chk_read_stretch: assert property (ev_fall && cnt_q == `ISA_CNT_ACK && nxt_q == ISA_TX && st_q != ISA_WAIT
      && !MASTER_MODE_I && ENABLE_I |=> SCL_OE_O && flag_q && st_q == ISA_TX) else $error("no stretch");
   chk_gc_no_ua: assert property (gc_q |-> !ua_q && !ua_pend_q)
      else $error("general call set address update");
   chk_disable_clear: assert property (!ENABLE_I |=> !ss_q && !ps_q && st_q == ISA_IDLE && BUS_FREE_O)
      else $error("disable left status set");

   cov_write_byte: cover property (st_q == ISA_RX && ev_fall && cnt_q == `ISA_CNT_ACK && ack_q);
   cov_read_byte: cover property (st_q == ISA_TX && ev_fall && cnt_q == `ISA_CNT_ACK);
   cov_ten_bit: cover property ($rose(armed_q));
   cov_overflow: cover property ($rose(ovf_q));

endmodule

//--- testbench/isa_bus_master.sv
// Bus master model for the slave bench, open drain on both lines
`timescale 1ns/1ns
module isa_bus_master
#(
   parameter int HALF = 300
)
(
   // Resolved bus levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Pull-low enables
   output logic scl_oe_o,
   output logic sda_oe_o
);
   // ==========================================
   // Both lines released, so they float to the pull-up
   initial
   begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   // One clock pulse; waits out a stretch, samples SDA mid-high
   task automatic pulse(output logic s);
      scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #(HALF/2) s = sda_i;
      #(HALF/2) scl_oe_o = 1'b1;
   endtask

   // Start or repeated start: SDA falls while SCL is high
   task automatic start_c();
      #(HALF/2) sda_oe_o = 1'b0;
      #(HALF/2) scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #HALF sda_oe_o = 1'b1;
      #HALF scl_oe_o = 1'b1;
   endtask

   // Stop: SDA rises while SCL is high
   task automatic stop_c();
      #(HALF/2) sda_oe_o = 1'b1;
      #(HALF/2) scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #HALF sda_oe_o = 1'b0;
      #HALF;
   endtask

   // Eight bits out, MSB first, then the slave's acknowledge
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         #(HALF/2) sda_oe_o = !b[i];
         #(HALF/2) pulse(s);
      end
      #(HALF/2) sda_oe_o = 1'b0;
      #(HALF/2) pulse(s);
      ack = !s;
   endtask

   // Eight bits in, then our acknowledge or NACK
   task automatic rd_byte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         #(HALF/2) sda_oe_o = 1'b0;
         #(HALF/2) pulse(b[i]);
      end
      #(HALF/2) sda_oe_o = ack;
      #(HALF/2) pulse(s);
   endtask
endmodule

//--- testbench/tb_isa_slave.sv
// Self-checking bench for the two-wire slave addressing engine
`timescale 1ns/1ns
module tb_isa_slave;
   import isa_pkg::*;
   // ==========================================
   // Stimulus and observed signals
   logic clk = 0, lclk = 0, rstn = 0, ack;
   logic en = 0, ten = 0, mst = 0, gc = 0, slp = 0, ie = 0;
   logic [5:0] stb = 6'h00; // addr wr, buf wr, buf rd, flag clr, ovf clr, release
   isa_byte_t adat = 8'h00, bdat = 8'h00, got, bufo, owno;
   logic scl, sda, m_scl, m_sda, s_scl, s_sda;
   logic flag, full, ovf, ua, dir, dna, st, sp, free, crel, wake;
   int n_mismatch = 0, compares = 0;
   isa_byte_t dv[3] = '{8'h33, 8'h44, 8'h55}, eb[3] = '{8'h33, 8'h33, 8'h55};
   logic ea[3] = '{1'b1, 1'b0, 1'b0}, eo[3] = '{1'b0, 1'b1, 1'b1};

   // Core clock 4 ns, link clock 30 ns with its own phase
   initial forever #2 clk = ~clk;
   initial
   begin
      #7;
      forever #15 lclk = ~lclk;
   end

   // Open-drain wires with pull-ups
   assign scl = !(m_scl | s_scl);
   assign sda = !(m_sda | s_sda);

   // ==========================================
   // Design and bus master
   isa_slave DUT
   (
      .CLK_I(clk), .RESETN_I(rstn), .LINK_CLK_I(lclk),
      .SCL_I(scl), .SCL_O(), .SCL_OE_O(s_scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(s_sda),
      .ENABLE_I(en), .TEN_BIT_I(ten), .MASTER_MODE_I(mst), .GEN_CALL_EN_I(gc), .SLEEP_I(slp),
      .EVENT_IE_I(ie), .ADDR_WR_I(stb[0]), .ADDR_DATA_I(adat), .BUF_WR_I(stb[1]),
      .BUF_DATA_I(bdat), .BUF_RD_I(stb[2]), .FLAG_CLR_I(stb[3]), .OVF_CLR_I(stb[4]),
      .CLK_RELEASE_SET_I(stb[5]), .BUF_DATA_O(bufo), .OWN_ADDR_O(owno),
      .SERIAL_EVENT_FLAG_O(flag), .BUFFER_FULL_O(full), .RECEIVE_OVERFLOW_O(ovf),
      .UPDATE_ADDRESS_O(ua), .DIR_READ_O(dir), .DATA_NOT_ADDR_O(dna), .START_SEEN_O(st),
      .STOP_SEEN_O(sp), .BUS_FREE_O(free), .CLOCK_RELEASE_O(crel), .WAKE_O(wake)
   );
   isa_bus_master u_m
   (
      .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda)
   );

   // ==========================================
   // Compare, strobe and wait helpers
   task automatic cv(string n, isa_byte_t e, isa_byte_t g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cb(string n, logic e, logic g);
      cv(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic pulse(int i);
      @(posedge clk);
      #1 stb[i] = 1'b1;
      @(posedge clk);
      #1 stb[i] = 1'b0;
   endtask
   // Lets a pin event cross into the core clock
   task automatic wt();
      repeat (100) @(posedge clk);
      #1;
   endtask
   // Firmware feeds one transmit byte while SCL is stretched
   task automatic fw_tx(isa_byte_t d);
      wait (flag === 1'b1);
      wt();
      cb("scl_hold", 1'b1, s_scl);
      cb("crel_hold", 1'b0, crel);
      pulse(3);
      pulse(2);
      bdat = d;
      pulse(1);
      pulse(5);
      cb("crel_set", 1'b1, crel);
   endtask
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #380000;
      n_mismatch++;
      end_sim();
   end

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      cb("free", 1'b1, free);
      cb("crel", 1'b1, crel);
      cb("flag", 1'b0, flag);
      en = 1'b1;
      slp = 1'b1;
      ie = 1'b1;
      adat = 8'h5a;
      pulse(0);
      wt();
      // Seven-bit write, then the overflow table
      u_m.start_c();
      wt();
      cb("busy", 1'b0, free);
      u_m.wr_byte(8'h5a, ack);
      wt();
      cb("ack_a", 1'b1, ack);
      cv("buf_a", 8'h5a, bufo);
      cb("dir_a", 1'b0, dir);
      cb("dna_a", 1'b0, dna);
      cb("wake", 1'b1, wake);
      pulse(2);
      cb("full_clr", 1'b0, full);
      for (int i = 0; i < 3; i++)
      begin
         pulse(3);
         u_m.wr_byte(dv[i], ack);
         wt();
         cb("ack_d", ea[i], ack);
         cv("buf_d", eb[i], bufo);
         cb("ovf_d", eo[i], ovf);
         cb("flag_d", 1'b1, flag);
         cb("dna_d", 1'b1, dna);
         if (i == 1)
            pulse(2);
      end
      pulse(4);
      cb("ovf_clr", 1'b0, ovf);
      u_m.stop_c();
      wt();
      cb("stop", 1'b1, sp);
      // Seven-bit read, two bytes, master ends with NACK
      pulse(2);
      pulse(3);
      u_m.start_c();
      u_m.wr_byte(8'h5b, ack);
      wt();
      cb("ack_r", 1'b1, ack);
      cb("dir_r", 1'b1, dir);
      fork
         u_m.rd_byte(got, 1'b1);
         fw_tx(8'hc3);
      join
      cv("tx1", 8'hc3, got);
      wt();
      cb("flag_t", 1'b1, flag);
      cb("dir_ack", 1'b1, dir);
      fork
         u_m.rd_byte(got, 1'b0);
         fw_tx(8'h3c);
      join
      cv("tx2", 8'h3c, got);
      wt();
      cb("dir_nack", 1'b0, dir);
      u_m.stop_c();
      // Address not ours
      pulse(3);
      u_m.start_c();
      u_m.wr_byte(8'h24, ack);
      wt();
      cb("ack_x", 1'b0, ack);
      cb("flag_x", 1'b0, flag);
      u_m.stop_c();
      // Ten-bit write, then restart into transmit
      @(posedge clk);
      #1 ten = 1'b1;
      gc = 1'b1;
      adat = 8'hf2;
      pulse(0);
      u_m.start_c();
      u_m.wr_byte(8'hf2, ack);
      wt();
      cb("ack_h", 1'b1, ack);
      cb("ua_h", 1'b1, ua);
      wt();
      cb("hold_h", 1'b1, s_scl);
      pulse(2);
      pulse(3);
      adat = 8'h9c;
      pulse(0);
      wt();
      cv("own_l", 8'h9c, owno);
      cb("ua_clr", 1'b0, ua);
      cb("rel_h", 1'b0, s_scl);
      u_m.wr_byte(8'h9c, ack);
      wt();
      cb("ack_l", 1'b1, ack);
      cb("ua_l", 1'b1, ua);
      adat = 8'hf2;
      pulse(0);
      pulse(2);
      pulse(3);
      u_m.wr_byte(8'h77, ack);
      wt();
      cv("buf_10", 8'h77, bufo);
      pulse(2);
      pulse(3);
      u_m.start_c();
      u_m.wr_byte(8'hf3, ack);
      wt();
      cb("ack_rs", 1'b1, ack);
      cb("dir_rs", 1'b1, dir);
      cb("full_rs", 1'b1, full);
      fork
         u_m.rd_byte(got, 1'b0);
         fw_tx(8'ha5);
      join
      cv("tx10", 8'ha5, got);
      u_m.stop_c();
      // General call in ten-bit mode
      pulse(2);
      pulse(3);
      u_m.start_c();
      u_m.wr_byte(8'h00, ack);
      wt();
      cb("ack_g", 1'b1, ack);
      cb("full_g", 1'b1, full);
      cb("flag_g", 1'b1, flag);
      cb("ua_g", 1'b0, ua);
      pulse(2);
      u_m.wr_byte(8'h11, ack);
      wt();
      cv("buf_g", 8'h11, bufo);
      u_m.stop_c();
      // Master mode events, then disable
      @(posedge clk);
      #1 ten = 1'b0;
      mst = 1'b1;
      pulse(3);
      u_m.start_c();
      wt();
      cb("flag_s", 1'b1, flag);
      pulse(3);
      u_m.stop_c();
      wt();
      cb("flag_p", 1'b1, flag);
      en = 1'b0;
      wt();
      cb("st_dis", 1'b0, st);
      cb("sp_dis", 1'b0, sp);
      // Reset in mid transfer
      en = 1'b1;
      mst = 1'b0;
      adat = 8'h5a;
      pulse(0);
      pulse(2);
      u_m.start_c();
      u_m.wr_byte(8'h5b, ack);
      wt();
      rstn = 1'b0;
      repeat (30) @(posedge clk);
      #1;
      cb("rst_scl", 1'b0, s_scl);
      cb("rst_dir", 1'b0, dir);
      rstn = 1'b1;
      u_m.stop_c();
      end_sim();
   end
endmodule
